// *** bench/pctl_cpl_partner.sv ***
// Completer model answering the block's outgoing non-posted requests
module pctl_cpl_partner (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       req_issue,
    input  wire logic       answer_en,
    input  wire logic [7:0] answer_delay,
    output logic            cpl_received
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_q;
    logic       busy_q;
    // Answers after the delay, or stays silent
    always_ff @(posedge clk) begin
        cpl_received <= 1'h0;
        if (srst) begin
            busy_q <= 1'h0;
            cnt_q <= 8'h00;
        end else if (req_issue && answer_en) begin
            busy_q <= 1'h1;
            cnt_q <= answer_delay;
        end else if (busy_q && cnt_q == 8'h00) begin
            busy_q <= 1'h0;
            cpl_received <= 1'h1;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule

// *** bench/pctl_tl_config_props.sv ***
// Assertion checker for the transaction layer config block
module pctl_tl_config_props (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [11:0] np_data_credit_limit,
    input wire logic [7:0]  np_header_credit_limit,
    input wire logic [11:0] posted_data_credit_limit,
    input wire logic [7:0]  posted_header_credit_limit,
    input wire logic        cpl_received,
    input wire logic        cpl_timeout,
    input wire logic        msg_valid,
    input wire logic        user_request_stream_valid,
    input wire logic        msg_ur_drop,
    input wire logic        lock_req_valid,
    input wire logic        lock_req_fwd,
    input wire logic        lock_cpl_locked,
    input wire logic        user_lock_rd_req,
    input wire logic        user_lock_rd_grant,
    input wire logic        cfg_valid,
    input wire logic        cfg_type0,
    input wire logic [2:0]  cfg_func,
    input wire logic [9:0]  cfg_reg_num,
    input wire logic        cfg_extension_port_valid,
    input wire logic [2:0]  cfg_extension_port_func,
    input wire logic [9:0]  cfg_extension_port_reg,
    input wire logic        cfg_int_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////////
    chk_np_credits: assert property (
        np_data_credit_limit == 12'h028 && np_header_credit_limit == 8'h20)
        else $error("non-posted credit limit wrong");
    chk_p_credits: assert property (
        (posted_data_credit_limit == 12'h198 || posted_data_credit_limit == 12'h0CC)
        && posted_header_credit_limit == 8'h20) else $error("posted credit limit wrong");
    chk_timeout_pulse: assert property (
        cpl_timeout |-> !$past(cpl_received) ##1 !cpl_timeout)
        else $error("timeout pulse wrong");
    chk_msg_route: assert property (
        msg_valid |=> (user_request_stream_valid ^ msg_ur_drop))
        else $error("message neither forwarded nor dropped");
    chk_msg_cause: assert property (
        (user_request_stream_valid || msg_ur_drop) |-> $past(msg_valid))
        else $error("message output without cause");
    chk_lock_pair: assert property (
        lock_req_fwd |-> lock_cpl_locked && $past(lock_req_valid))
        else $error("locked forward without locked completion");
    chk_grant_cause: assert property (
        user_lock_rd_grant |-> $past(user_lock_rd_req)) else $error("grant without request");
    chk_cfg_split: assert property (
        cfg_valid |=> (cfg_extension_port_valid ^ cfg_int_valid))
        else $error("config access lost or doubled");
    chk_ext_fields: assert property (
        cfg_extension_port_valid |-> $past(cfg_type0) && $past(cfg_func) == cfg_extension_port_func
        && $past(cfg_reg_num) == cfg_extension_port_reg) else $error("extension fields wrong");
    chk_ext_range: assert property (
        cfg_extension_port_valid |-> (cfg_extension_port_reg inside {[10'h010:10'h01F]}
        || cfg_extension_port_reg >= 10'h100)) else $error("extension register out of range");
    chk_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside read cycle");
    cov_drop: cover property (msg_ur_drop);
    cov_ext: cover property (cfg_extension_port_valid);
    cov_timeout: cover property (cpl_timeout);
    cov_lock: cover property (lock_req_fwd);
endmodule

bind pctl_tl_config pctl_tl_config_props u_props (.*);

// *** bench/tb_top.sv ***
// Self-checking testbench for the transaction layer config block
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] DEVS = 32'h2B2A_1A1B; // Arbitrary
    localparam logic [15:0] VEN = 16'h5A5A; // Arbitrary
    localparam logic [15:0] SVEN = 16'hA5A5; // Arbitrary
    localparam logic [15:0] REVS = 16'h0207;
    localparam logic [47:0] CLS = 48'h0C0330_058001;
    localparam logic [31:0] SUBS = 32'h3E3D_3C3B; // Arbitrary
    localparam logic [5:0]  PINS = 6'h21;
    logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, req_issue = 0, msg_valid = 0;
    logic msg_id_routed = 0, lock_req_valid = 0, user_lock_rd_req = 0, cfg_valid = 0;
    logic cfg_type0 = 0, answer_en = 0, cpl_received, irq, cpl_timeout, msg_ur_drop;
    logic [7:0] reg_addr = 0, answer_delay = 3, np_header_credit_limit, posted_header_credit_limit;
    logic [31:0] reg_wdata = 0, msg_data = 0, reg_rdata, user_request_stream_data, cfg_int_rdata;
    logic [15:0] msg_target_id = 0;
    logic [2:0] cfg_func = 0, cfg_extension_port_func;
    logic [9:0] cfg_reg_num = 0, cfg_extension_port_reg;
    logic [11:0] np_data_credit_limit, posted_data_credit_limit;
    logic user_request_stream_valid, lock_req_fwd, lock_cpl_locked, user_lock_rd_grant;
    logic cfg_extension_port_valid, cfg_int_valid;
    int err_count = 0, samples_checked = 0, n;
    always #25 clk = ~clk;
    pctl_tl_config #(.CPL_TO_LIMIT_R1(24'h000064), .CPL_TO_LIMIT_R2(28'h00000C8),
        .VENDOR_ID(VEN), .SUBSYS_VENDOR_ID(SVEN), .PF_DEVICE_ID(DEVS), .PF_REVISION_ID(REVS),
        .PF_CLASS_CODE(CLS), .PF_SUBSYSTEM_ID(SUBS), .PF_INTERRUPT_PIN(PINS)) u_dut (.*);
    pctl_cpl_partner u_partner (.*);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic msg(input logic idr, input logic [15:0] tid, input logic fwd);
        @(posedge clk);
        msg_valid <= 1'h1;
        msg_id_routed <= idr;
        msg_target_id <= tid;
        msg_data <= {tid, 16'hC0DE};
        @(posedge clk);
        msg_valid <= 1'h0;
        #1;
        chk(32'({user_request_stream_valid, msg_ur_drop}), 32'({fwd, !fwd}));
        if (fwd) chk(user_request_stream_data, {tid, 16'hC0DE});
    endtask
    task automatic lk(input logic l, input logic u, input logic [2:0] exp);
        @(posedge clk);
        lock_req_valid <= l;
        user_lock_rd_req <= u;
        @(posedge clk);
        lock_req_valid <= 1'h0;
        user_lock_rd_req <= 1'h0;
        #1;
        chk(32'({lock_req_fwd, lock_cpl_locked, user_lock_rd_grant}), 32'(exp));
    endtask
    task automatic cf(input logic t0, input logic [2:0] f, input logic [9:0] r, input logic ext,
        input logic [31:0] exp);
        @(posedge clk);
        cfg_valid <= 1'h1;
        cfg_type0 <= t0;
        cfg_func <= f;
        cfg_reg_num <= r;
        @(posedge clk);
        cfg_valid <= 1'h0;
        #1;
        chk(32'({cfg_extension_port_valid, cfg_int_valid}), 32'({ext, !ext}));
        if (ext) chk(32'({cfg_extension_port_func, cfg_extension_port_reg}), 32'({f, r}));
        else chk(cfg_int_rdata, exp);
    endtask
    task automatic to(input logic [3:0] code, input logic en, input int lo, input int hi);
        wr(8'h04, 32'(code));
        @(posedge clk);
        answer_en <= en;
        req_issue <= 1'h1;
        @(posedge clk);
        req_issue <= 1'h0;
        #1;
        for (n = 0; n < 60 && cpl_timeout !== 1'h1; n++) @(posedge clk) #1;
        chk(32'(n >= lo && n <= hi), 32'h1);
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #1_000_000;
        err_count++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        rdc(8'h00, 32'h11);
        rdc(8'h1C, 32'h0002_0028);
        rdc(8'h20, 32'h0002_0198);
        wr(8'h1C, 32'h0);
        rdc(8'h1C, 32'h0002_0028);
        rdc(8'h30, 32'h0);
        $display("test registers done");
        to(4'h5, 1'h1, 60, 60);
        to(4'h5, 1'h0, 7, 11);
        rdc(8'h24, 32'h2);
        to(4'h6, 1'h0, 15, 19);
        to(4'h0, 1'h0, 60, 60);
        rdc(8'h24, 32'h1);
        rdc(8'h10, 32'h1);
        $display("test timeout done");
        wr(8'h18, 32'h2);
        msg(1'h1, 16'h0001, 1'h1);
        msg(1'h1, 16'h0005, 1'h0);
        msg(1'h0, 16'h0105, 1'h1);
        @(posedge clk) #1 chk(32'(irq), 32'h1);
        wr(8'h18, 32'h0);
        @(posedge clk) #1 chk(32'(irq), 32'h0);
        wr(8'h14, 32'h3);
        rdc(8'h10, 32'h0);
        rdc(8'h14, 32'h0);
        wr(8'h00, 32'h10);
        msg(1'h1, 16'h0005, 1'h1);
        $display("test messages done");
        lk(1'h1, 1'h1, 3'h0);
        rdc(8'h10, 32'hC);
        wr(8'h00, 32'h19);
        lk(1'h1, 1'h0, 3'h6);
        wr(8'h00, 32'h08);
        lk(1'h0, 1'h1, 3'h1);
        $display("test locked done");
        wr(8'h00, 32'h17);
        cf(1'h1, 3'h0, 10'h010, 1'h1, 32'h0);
        cf(1'h1, 3'h1, 10'h01F, 1'h1, 32'h0);
        cf(1'h1, 3'h0, 10'h020, 1'h0, 32'h0);
        cf(1'h1, 3'h2, 10'h010, 1'h0, 32'h0);
        cf(1'h0, 3'h0, 10'h010, 1'h0, 32'h0);
        cf(1'h1, 3'h1, 10'h100, 1'h1, 32'h0);
        cf(1'h1, 3'h0, 10'h3FF, 1'h1, 32'h0);
        cf(1'h1, 3'h0, 10'h0FF, 1'h0, 32'h0);
        for (int f = 0; f < 2; f++) begin
            cf(1'h1, 3'(f), 10'h000, 1'h0, {DEVS[f*16+:16], VEN});
            cf(1'h1, 3'(f), 10'h002, 1'h0, {CLS[f*24+:24], REVS[f*8+:8]});
            cf(1'h1, 3'(f), 10'h00B, 1'h0, {SUBS[f*16+:16], SVEN});
            cf(1'h1, 3'(f), 10'h00F, 1'h0, {21'h0, PINS[f*3+:3], 8'hFF});
        end
        wr(8'h00, 32'h11);
        cf(1'h1, 3'h0, 10'h010, 1'h0, 32'h0);
        cf(1'h1, 3'h0, 10'h100, 1'h0, 32'h0);
        $display("test config done");
        report_and_stop();
    end
endmodule

// *** src/pctl_params.svh ***
// Offsets, fields, reset values and timing constants of the transaction layer config block
`ifndef PCTL_PARAMS_SVH
`define PCTL_PARAMS_SVH

`define PCTL_AW              8
`define PCTL_DW              32
`define PCTL_REG_CTRL        8'h00
`define PCTL_REG_DEVCTL2     8'h04
`define PCTL_REG_FUNC_EN     8'h08
`define PCTL_REG_BUS_NUM     8'h0C
`define PCTL_REG_STATUS      8'h10
`define PCTL_REG_CLEAR       8'h14
`define PCTL_REG_IRQ_EN      8'h18
`define PCTL_REG_NP_CREDITS  8'h1C
`define PCTL_REG_P_CREDITS   8'h20
`define PCTL_REG_TO_STATE    8'h24

`define PCTL_CTRL_RID_CHK    0
`define PCTL_CTRL_LEG_EXT    1
`define PCTL_CTRL_EXT_EXT    2
`define PCTL_CTRL_LEGACY     3
`define PCTL_CTRL_UPSTREAM   4
`define PCTL_CTRL_W          5
`define PCTL_CTRL_RESET      5'h11

`define PCTL_EV_CPL_TO       0
`define PCTL_EV_MSG_UR       1
`define PCTL_EV_LOCK_UR      2
`define PCTL_EV_LOCK_REJ     3
`define PCTL_EV_W            4

`define PCTL_TO_CODE_R1      4'h5
`define PCTL_TO_CODE_R2      4'h6

`define PCTL_NPD_DEFAULT     12'h028
`define PCTL_NPH_DEFAULT     8'h20
`define PCTL_PD_DEFAULT      12'h198
`define PCTL_PD_ALT          12'h0CC
`define PCTL_PH_DEFAULT      8'h20
`define PCTL_TO_R1_DEFAULT   24'hBEBC20
`define PCTL_TO_R2_DEFAULT   28'h17D7840

`define PCTL_CLK_PERIOD_NS   50
`define PCTL_TICK_NS         4
`define PCTL_HALF_TICKS_PER_CLK ((2 * `PCTL_CLK_PERIOD_NS) / `PCTL_TICK_NS)

`define PCTL_LEG_CFG_LO      10'h010
`define PCTL_LEG_CFG_HI      10'h01F
`define PCTL_EXT_CFG_LO      10'h100
`define PCTL_EXT_CFG_HI      10'h3FF
`define PCTL_HDR_ID          10'h000
`define PCTL_HDR_CLASS       10'h002
`define PCTL_HDR_SUBSYS      10'h00B
`define PCTL_HDR_INTR        10'h00F
`define PCTL_INT_LINE_NONE   8'hFF

`endif

// *** src/pctl_pkg.sv ***
// Types of the transaction layer config block
package pctl_pkg;
    typedef enum logic [1:0] {
        PCTL_TO_IDLE    = 2'b00,
        PCTL_TO_WAIT    = 2'b01,
        PCTL_TO_EXPIRED = 2'b10
    } pctl_to_state_t;
endpackage

// *** src/pctl_tl_config.sv ***
// Transaction layer configuration: credits, completion timeout, message, lock and config steering
// Summary of operation
// R1 - Non-posted data credit limit is 12 bits, default 28h (640 bytes).
// R2 - Non-posted header credit limit is 8 bits, default 20h (32 packets).
// R3 - Posted data credit limit is 12 bits, 198h or CCh allowed.
// R4 - Posted header credit limit is 8 bits, default 20h (32 packets).
// R5 - Range code 0101 uses 24-bit limit in 4 ns ticks for timeout.
// R6 - Range code 0110 uses separate 28-bit limit in 4 ns ticks.
// R7 - Legacy upstream port forwards locked requests and answers with locked completions.
// R8 - Legacy non-upstream port lets user logic issue locked reads.
// R9 - RID check on, upstream port: mismatching ID-routed message is Unsupported Request, dropped.
// R10 - RID check off: every message goes to the user request stream.
// R11 - Legacy extension: Type0 config regs 10h-1Fh go to extension port.
// R12 - Extended extension: Type0 config regs 100h-3FFh go to extension port.
// R13 - Each physical function returns its own 16-bit device identifier.
// R14 - Per-function 8-bit revision identifier, also reported by its virtual functions.
// R15 - 24-bit class code: base, subclass, programming interface; shared with VFs.
// R16 - Per-function 16-bit subsystem identifier shared by its virtual functions.
// R17 - 3-bit interrupt pin: 1..4 select INTA..INTD, 0 means none.
// R18 - Limits and identities are static values fixed before traffic starts.
`include "pctl_params.svh"

module pctl_tl_config #(
    parameter int                  NUM_PF            = 2,
    parameter logic [11:0]         NP_DATA_CREDITS   = `PCTL_NPD_DEFAULT,
    parameter logic [7:0]          NP_HDR_CREDITS    = `PCTL_NPH_DEFAULT,
    parameter logic [11:0]         P_DATA_CREDITS    = `PCTL_PD_DEFAULT,
    parameter logic [7:0]          P_HDR_CREDITS     = `PCTL_PH_DEFAULT,
    parameter logic [23:0]         CPL_TO_LIMIT_R1   = `PCTL_TO_R1_DEFAULT,
    parameter logic [27:0]         CPL_TO_LIMIT_R2   = `PCTL_TO_R2_DEFAULT,
    parameter logic [15:0]         VENDOR_ID         = 16'h1234, // Arbitrary
    parameter logic [15:0]         SUBSYS_VENDOR_ID  = 16'h1234, // Arbitrary
    parameter logic [NUM_PF*16-1:0] PF_DEVICE_ID     = {NUM_PF{16'h0001}}, // Arbitrary
    parameter logic [NUM_PF*8-1:0]  PF_REVISION_ID   = {NUM_PF{8'h00}},
    parameter logic [NUM_PF*24-1:0] PF_CLASS_CODE    = {NUM_PF{24'h058000}},
    parameter logic [NUM_PF*16-1:0] PF_SUBSYSTEM_ID  = {NUM_PF{16'h0001}}, // Arbitrary
    parameter logic [NUM_PF*3-1:0]  PF_INTERRUPT_PIN = {NUM_PF{3'h1}}
) (
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic [`PCTL_AW-1:0]  reg_addr,
    input  wire logic [`PCTL_DW-1:0]  reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [`PCTL_DW-1:0]  reg_rdata,
    output logic                      irq,
    output logic      [11:0]          np_data_credit_limit,
    output logic      [7:0]           np_header_credit_limit,
    output logic      [11:0]          posted_data_credit_limit,
    output logic      [7:0]           posted_header_credit_limit,
    input  wire logic                 req_issue,
    input  wire logic                 cpl_received,
    output logic                      cpl_timeout,
    input  wire logic                 msg_valid,
    input  wire logic                 msg_id_routed,
    input  wire logic [15:0]          msg_target_id,
    input  wire logic [31:0]          msg_data,
    output logic                      user_request_stream_valid,
    output logic      [31:0]          user_request_stream_data,
    output logic                      msg_ur_drop,
    input  wire logic                 lock_req_valid,
    output logic                      lock_req_fwd,
    output logic                      lock_cpl_locked,
    input  wire logic                 user_lock_rd_req,
    output logic                      user_lock_rd_grant,
    input  wire logic                 cfg_valid,
    input  wire logic                 cfg_type0,
    input  wire logic [2:0]           cfg_func,
    input  wire logic [9:0]           cfg_reg_num,
    output logic                      cfg_extension_port_valid,
    output logic      [2:0]           cfg_extension_port_func,
    output logic      [9:0]           cfg_extension_port_reg,
    output logic                      cfg_int_valid,
    output logic      [31:0]          cfg_int_rdata
);

    ////////////////////////////////////////////////////////////////////////////
    // Software registers
    logic [`PCTL_CTRL_W-1:0] ctrl_q;
    logic [3:0]              devctl2_q;
    logic [7:0]              func_en_q;
    logic [7:0]              bus_num_q;
    logic [`PCTL_EV_W-1:0]   status_q;
    logic [`PCTL_EV_W-1:0]   irq_en_q;
    logic [`PCTL_EV_W-1:0]   events;
    logic [`PCTL_DW-1:0]     rdata_d;
    logic [`PCTL_DW-1:0]     rdata_q;
    pctl_pkg::pctl_to_state_t to_state_q;

    logic rid_chk_en;
    logic leg_ext_en;
    logic ext_ext_en;
    logic legacy_endpoint_sel;
    logic upstream_port_sel;

    assign rid_chk_en          = ctrl_q[`PCTL_CTRL_RID_CHK];
    assign leg_ext_en          = ctrl_q[`PCTL_CTRL_LEG_EXT];
    assign ext_ext_en          = ctrl_q[`PCTL_CTRL_EXT_EXT];
    assign legacy_endpoint_sel = ctrl_q[`PCTL_CTRL_LEGACY];
    assign upstream_port_sel   = ctrl_q[`PCTL_CTRL_UPSTREAM];

    // Function enabled and present
    function automatic logic fn_enabled(input logic [2:0] fn, input logic [7:0] en);
        fn_enabled = (32'(fn) < NUM_PF) && en[fn];
    endfunction

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q    <= `PCTL_CTRL_RESET;
            devctl2_q <= 4'h0;
            func_en_q <= 8'(({NUM_PF{1'b1}}));
            bus_num_q <= 8'h00;
            irq_en_q  <= '0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `PCTL_REG_CTRL:    ctrl_q    <= reg_wdata[`PCTL_CTRL_W-1:0];
                `PCTL_REG_DEVCTL2: devctl2_q <= reg_wdata[3:0];
                `PCTL_REG_FUNC_EN: func_en_q <= reg_wdata[7:0];
                `PCTL_REG_BUS_NUM: bus_num_q <= reg_wdata[7:0];
                `PCTL_REG_IRQ_EN:  irq_en_q  <= reg_wdata[`PCTL_EV_W-1:0];
                default: ;
            endcase
        end
    end

    // Sticky status, set wins over clear
    always_ff @(posedge clk) begin
        if (srst) begin
            status_q <= '0;
        end else if (reg_wr && reg_addr == `PCTL_REG_CLEAR) begin
            status_q <= (status_q & ~reg_wdata[`PCTL_EV_W-1:0]) | events;
        end else begin
            status_q <= status_q | events;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |((status_q | events) & irq_en_q);
        end
    end

    always_comb begin
        rdata_d = '0;
        unique case (reg_addr)
            `PCTL_REG_CTRL:       rdata_d[`PCTL_CTRL_W-1:0] = ctrl_q;
            `PCTL_REG_DEVCTL2:    rdata_d[3:0] = devctl2_q;
            `PCTL_REG_FUNC_EN:    rdata_d[7:0] = func_en_q;
            `PCTL_REG_BUS_NUM:    rdata_d[7:0] = bus_num_q;
            `PCTL_REG_STATUS:     rdata_d[`PCTL_EV_W-1:0] = status_q;
            `PCTL_REG_IRQ_EN:     rdata_d[`PCTL_EV_W-1:0] = irq_en_q;
            `PCTL_REG_NP_CREDITS: rdata_d[19:0] = {NP_HDR_CREDITS, NP_DATA_CREDITS};
            `PCTL_REG_P_CREDITS:  rdata_d[19:0] = {P_HDR_CREDITS, P_DATA_CREDITS};
            `PCTL_REG_TO_STATE:   rdata_d[1:0] = to_state_q;
            default:              rdata_d = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Advertised receive credit limits, static
    always_ff @(posedge clk) begin
        if (srst) begin
            np_data_credit_limit       <= NP_DATA_CREDITS; // R1 R18
            np_header_credit_limit     <= NP_HDR_CREDITS; // R2
            posted_data_credit_limit   <= P_DATA_CREDITS; // R3
            posted_header_credit_limit <= P_HDR_CREDITS; // R4
        end else begin
            np_data_credit_limit       <= NP_DATA_CREDITS;
            np_header_credit_limit     <= NP_HDR_CREDITS;
            posted_data_credit_limit   <= P_DATA_CREDITS;
            posted_header_credit_limit <= P_HDR_CREDITS;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Completion timeout, elapsed time kept in half 4 ns ticks
    logic [29:0] elapsed_q;
    logic [29:0] limit_half;
    logic        to_armed;
    logic        to_hit;

    always_comb begin
        limit_half = '0;
        to_armed   = 1'b0;
        if (devctl2_q == `PCTL_TO_CODE_R1) begin
            limit_half = {5'h00, CPL_TO_LIMIT_R1, 1'b0}; // R5
            to_armed   = 1'b1;
        end else if (devctl2_q == `PCTL_TO_CODE_R2) begin
            limit_half = {1'b0, CPL_TO_LIMIT_R2, 1'b0}; // R6
            to_armed   = 1'b1;
        end
    end

    assign to_hit = to_armed && (elapsed_q >= limit_half);

    always_ff @(posedge clk) begin
        if (srst) begin
            to_state_q  <= pctl_pkg::PCTL_TO_IDLE;
            elapsed_q   <= '0;
            cpl_timeout <= 1'b0;
        end else begin
            cpl_timeout <= 1'b0;
            unique case (to_state_q)
                pctl_pkg::PCTL_TO_IDLE: begin
                    elapsed_q <= '0;
                    if (req_issue) begin
                        to_state_q <= pctl_pkg::PCTL_TO_WAIT;
                    end
                end
                pctl_pkg::PCTL_TO_WAIT: begin
                    if (cpl_received) begin
                        to_state_q <= pctl_pkg::PCTL_TO_IDLE;
                    end else if (to_hit) begin
                        to_state_q  <= pctl_pkg::PCTL_TO_EXPIRED; // R5 R6
                        cpl_timeout <= 1'b1;
                    end else begin
                        elapsed_q <= elapsed_q + 30'(`PCTL_HALF_TICKS_PER_CLK);
                    end
                end
                pctl_pkg::PCTL_TO_EXPIRED: begin
                    elapsed_q <= '0;
                    if (req_issue) begin
                        to_state_q <= pctl_pkg::PCTL_TO_WAIT;
                    end
                end
                default: begin
                    to_state_q <= pctl_pkg::PCTL_TO_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Received messages: requester ID check or pass through
    logic msg_match;
    logic msg_drop;

    assign msg_match = (msg_target_id[15:8] == bus_num_q) && (msg_target_id[7:3] == 5'h00)
                       && fn_enabled(msg_target_id[2:0], func_en_q);
    assign msg_drop  = msg_valid && rid_chk_en && upstream_port_sel && msg_id_routed
                       && !msg_match; // R9

    always_ff @(posedge clk) begin
        if (srst) begin
            user_request_stream_valid <= 1'b0;
            user_request_stream_data  <= '0;
            msg_ur_drop               <= 1'b0;
        end else begin
            user_request_stream_valid <= msg_valid && !msg_drop; // R10
            msg_ur_drop               <= msg_drop; // R9
            if (msg_valid && !msg_drop) begin
                user_request_stream_data <= msg_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Locked transactions
    logic lock_legacy_ep;
    logic lock_master_ok;

    assign lock_legacy_ep = legacy_endpoint_sel && upstream_port_sel;
    assign lock_master_ok = legacy_endpoint_sel && !upstream_port_sel;

    always_ff @(posedge clk) begin
        if (srst) begin
            lock_req_fwd       <= 1'b0;
            lock_cpl_locked    <= 1'b0;
            user_lock_rd_grant <= 1'b0;
        end else begin
            lock_req_fwd       <= lock_req_valid && lock_legacy_ep; // R7
            lock_cpl_locked    <= lock_req_valid && lock_legacy_ep; // R7
            user_lock_rd_grant <= user_lock_rd_req && lock_master_ok; // R8
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Type0 configuration steering and header answers
    logic to_ext;
    logic in_leg;
    logic in_ext;

    assign in_leg = (cfg_reg_num >= `PCTL_LEG_CFG_LO) && (cfg_reg_num <= `PCTL_LEG_CFG_HI);
    assign in_ext = (cfg_reg_num >= `PCTL_EXT_CFG_LO) && (cfg_reg_num <= `PCTL_EXT_CFG_HI);
    assign to_ext = cfg_valid && cfg_type0 && fn_enabled(cfg_func, func_en_q)
                    && ((leg_ext_en && in_leg) || (ext_ext_en && in_ext)); // R11 R12

    // Header word of one function
    function automatic logic [31:0] hdr_word(input logic [2:0] fn, input logic [9:0] rn);
        int i;
        i        = 32'(fn);
        hdr_word = 32'h0000_0000;
        if (i < NUM_PF) begin
            unique case (rn)
                `PCTL_HDR_ID:     hdr_word = {PF_DEVICE_ID[i*16 +: 16], VENDOR_ID};
                `PCTL_HDR_CLASS:  hdr_word = {PF_CLASS_CODE[i*24 +: 24], PF_REVISION_ID[i*8 +: 8]};
                `PCTL_HDR_SUBSYS: hdr_word = {PF_SUBSYSTEM_ID[i*16 +: 16], SUBSYS_VENDOR_ID};
                `PCTL_HDR_INTR:   hdr_word = {16'h0000, 5'h00, PF_INTERRUPT_PIN[i*3 +: 3],
                                              `PCTL_INT_LINE_NONE};
                default:          hdr_word = 32'h0000_0000;
            endcase
        end
    endfunction

    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_extension_port_valid <= 1'b0;
            cfg_extension_port_func  <= '0;
            cfg_extension_port_reg   <= '0;
            cfg_int_valid            <= 1'b0;
            cfg_int_rdata            <= '0;
        end else begin
            cfg_extension_port_valid <= to_ext; // R11 R12
            cfg_int_valid            <= cfg_valid && !to_ext;
            if (to_ext) begin
                cfg_extension_port_func <= cfg_func;
                cfg_extension_port_reg  <= cfg_reg_num;
            end
            if (cfg_valid && !to_ext) begin
                cfg_int_rdata <= hdr_word(cfg_func, cfg_reg_num); // R13 R14 R15 R16 R17
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt events
    always_comb begin
        events                     = '0;
        events[`PCTL_EV_CPL_TO]   = (to_state_q == pctl_pkg::PCTL_TO_WAIT) && !cpl_received
                                     && to_hit;
        events[`PCTL_EV_MSG_UR]   = msg_drop;
        events[`PCTL_EV_LOCK_UR]  = lock_req_valid && !lock_legacy_ep;
        events[`PCTL_EV_LOCK_REJ] = user_lock_rd_req && !lock_master_ok;
    end

endmodule
